// file: rtl/mbpq_defines.svh
// Offsets, field positions, reset values and timing counts of the profiling block.
// Assumes byte addresses on a 16-bit register address bus with one word per register.
`ifndef MBPQ_DEFINES_SVH
`define MBPQ_DEFINES_SVH

`define MBPQ_OFS_TX_CNT 16'h80ec
`define MBPQ_OFS_RX_CNT 16'h80f0
`define MBPQ_OFS_CLR_CNT 16'h80f4
`define MBPQ_OFS_CYC_CNT 16'h80f8
`define MBPQ_OFS_QT1 16'h80fc
`define MBPQ_OFS_QT2 16'h8100
`define MBPQ_OFS_TSF_STEP 16'h8104
`define MBPQ_OFS_NO_ACK_LOCATOR 16'h8108
`define MBPQ_OFS_ERR_MASK 16'h810c
`define MBPQ_OFS_SIFS_ADJ 16'h8114
`define MBPQ_OFS_MIC_CTL 16'h8118
`define MBPQ_OFS_MIC_SEL 16'h811c
`define MBPQ_OFS_CNT_CTL 16'h80e8

`define MBPQ_CTL_FREEZE 0
`define MBPQ_CTL_ZERO 1
`define MBPQ_CTL_STROBE 2

`define MBPQ_QT1_NEXT 15:0
`define MBPQ_QT1_EN 16
`define MBPQ_QT1_ACKCTS 17
`define MBPQ_QT2_PERIOD 15:0
`define MBPQ_QT2_DUR 31:16
`define MBPQ_TSF_TU 25:10
`define MBPQ_STEP_F 7:0
`define MBPQ_NO_ACK_LOCATOR_MASK 3:0
`define MBPQ_NO_ACK_LOCATOR_BIT 6:4
`define MBPQ_NO_ACK_LOCATOR_BYTE 8:7
`define MBPQ_NO_ACK_LOCATOR_BIT_MAX 3'h6
`define MBPQ_SIFS_F 7:0
`define MBPQ_MIC_CTL_F 15:0
`define MBPQ_MIC_EN 16
`define MBPQ_MIC_SEL_F 15:0
`define MBPQ_ERR_MASKED_MAX 8'h1f

`define MBPQ_RST_QT1 32'h00020000
`define MBPQ_RST_QT2 32'h00020001
`define MBPQ_RST_NO_ACK_LOCATOR 32'h000000cc
`define MBPQ_RST_TSF_STEP 8'h01

`define MBPQ_MIC_USE_ZERO 2'h0
`define MBPQ_MIC_USE_ONE 2'h1
`define MBPQ_MIC_USE_BIT 2'h2

`define MBPQ_CLK_PERIOD_NS 4
`define MBPQ_USEC_NS 1000
`define MBPQ_USEC_CYCLES (`MBPQ_USEC_NS / `MBPQ_CLK_PERIOD_NS)

`endif

// file: rtl/mbpq_pkg.sv
// Types of the profiling and quiet-time register block.
// Assumes mbpq_defines.svh supplies all numeric constants.
package mbpq_pkg;

   typedef struct packed {
      logic [31:0] tx_cnt;
      logic [31:0] rx_cnt;
      logic [31:0] clr_cnt;
      logic [31:0] cyc_cnt;
      logic ctl_freeze;
      logic ctl_zero;
      logic ctl_strobe;
      logic [15:0] next_quiet;
      logic quiet_en;
      logic quiet_ack_cts;
      logic [15:0] quiet_period;
      logic [15:0] quiet_dur;
      logic [7:0] tsf_step;
      logic [7:0] prescale;
      logic [31:0] sync_timer_step;
      logic [15:0] quiet_left;
      logic tx_quiet;
      logic [3:0] no_ack_locator_mask;
      logic [2:0] no_ack_locator_bit;
      logic [1:0] no_ack_locator_byte;
      logic [31:0] err_mask;
      logic [7:0] sifs_adj;
      logic [15:0] mic_ctl;
      logic mic_en;
      logic [15:0] mic_sel;
      logic [31:0] rdata;
      logic no_ack_hit;
      logic err_drop;
      logic err_keep;
      logic [9:0] ack_sifs;
      logic [7:0] mic_bits;
   } mbpq_state_t;

endpackage

// file: rtl/mbpq_regs.sv
// Baseband profiling counters, quiet-time scheduler and MAC side control registers.
// Assumes activity, error and QoS inputs come from logic on the same clock; the clock
// stops or clock_en drops during sleep.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "mbpq_defines.svh"

// How it works
// RQ1: Count cycles with transmit frame active in a 32-bit counter.
// RQ2: Count receive frame cycles and channel clear cycles in separate counters.
// RQ3: Count every clock cycle as the ratio denominator.
// RQ4: Counters move only on enabled clock edges, frozen during sleep.
// RQ5: Counter zero bit clears all four profiling counters.
// RQ6: Counter strobe bit increments all profiling counters every cycle.
// RQ7: Counter freeze bit holds all profiling counters.
// RQ8: Cycle counter at all ones halves all four counters together.
// RQ9: Software may write all four profiling counters.
// RQ10: Quiet time starts when next quiet equals sync timer bits 25 to 10.
// RQ11: Each match adds the quiet period to next quiet.
// RQ12: Quiet time kills transmit until quiet duration in time units elapses.
// RQ13: Quiet scheduling runs only while the quiet enable bit is high.
// RQ14: Second quiet register holds period low and duration high.
// RQ15: Each microsecond prescaler zero adds the step to the sync timer.
// RQ16: Policy value n means no acknowledge when mask bit n set.
// RQ17: No-ack field located by 2-bit byte and 3-bit bit offset, max 6.
// RQ18: Error number indexes mask; zero mask bit filters the frame.
// RQ19: Error numbers 32 and above are always filtered.
// RQ20: Subtract signed gap adjustment from the built-in table value.
// RQ21: Per position, control picks zero, one, selected bit or its inverse.
// RQ22: Hardware integrity calculation runs only while its enable bit is set.
// RQ23: Select register holds eight 2-bit TID bit choices.
// RQ24: Halving applies before the increment of the same cycle.
module mbpq_regs #(
   parameter int USEC_CYCLES = `MBPQ_USEC_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clock_en,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic tx_frame,
   input wire logic rx_frame,
   input wire logic rx_clear,
   input wire logic [1:0] qos_ack_policy,
   input wire logic bb_error_valid,
   input wire logic [7:0] bb_error_num,
   input wire logic [9:0] sifs_table_us,
   input wire logic [3:0] qos_tid,
   output logic tx_quiet,
   output logic quiet_ack_cts_enable,
   output logic [31:0] sync_timer,
   output logic no_ack_hit,
   output logic [2:0] no_ack_bit_position,
   output logic [1:0] no_ack_byte_position,
   output logic error_drop,
   output logic error_keep,
   output logic [9:0] ack_sifs_us,
   output logic [7:0] michael_tid_bits,
   output logic michael_hw_enable
);

   localparam logic [7:0] PRESCALE_TOP = 8'(USEC_CYCLES - 1);

   mbpq_pkg::mbpq_state_t st;
   mbpq_pkg::mbpq_state_t next_st;
   logic [7:0] mic_bit;

   function automatic logic [31:0] cnt_next(input logic [31:0] cur, input logic inc,
                                            input logic halve);
      logic [31:0] v;
      // Halving first keeps an all-ones counter from wrapping on the same edge
      if (halve) begin
         v = cur >> 1; // RQ8 RQ24
      end else begin
         v = cur;
      end
      cnt_next = v + {31'h0, inc};
   endfunction

   for (genvar i = 0; i < 8; i++) begin : g_mic
      logic [1:0] ctl;
      logic [1:0] sel;
      logic pick;
      logic use_bit;
      assign ctl = st.mic_ctl[2*i+1:2*i];
      assign sel = st.mic_sel[2*i+1:2*i]; // RQ23
      assign pick = qos_tid[sel];
      always_comb begin
         case (ctl)
            `MBPQ_MIC_USE_ZERO: begin
               use_bit = 1'b0; // RQ21
            end
            `MBPQ_MIC_USE_ONE: begin
               use_bit = 1'b1; // RQ21
            end
            `MBPQ_MIC_USE_BIT: begin
               use_bit = pick; // RQ21
            end
            default: begin
               use_bit = ~pick; // RQ21
            end
         endcase
      end
      assign mic_bit[i] = use_bit;
   end

   always_comb begin
      logic halve;
      logic tu_tick;
      logic [2:0] bitpos;
      logic quiet_match;
      logic inc_tx;
      logic inc_rx;
      logic inc_clr;
      logic [9:0] adj_wide;
      halve = 1'b0;
      tu_tick = 1'b0;
      bitpos = 3'h0;
      quiet_match = 1'b0;
      inc_tx = 1'b0;
      inc_rx = 1'b0;
      inc_clr = 1'b0;
      adj_wide = 10'h0;
      next_st = st;
      next_st.rdata = 32'h0;

      // Sync timer
      if (st.prescale == 8'h0) begin
         next_st.prescale = PRESCALE_TOP;
         next_st.sync_timer_step = st.sync_timer_step + {24'h0, st.tsf_step}; // RQ15
      end else begin
         next_st.prescale = st.prescale - 8'h1;
      end
      tu_tick = next_st.sync_timer_step[`MBPQ_TSF_TU] != st.sync_timer_step[`MBPQ_TSF_TU];


      // Quiet scheduler
      quiet_match = st.next_quiet == st.sync_timer_step[`MBPQ_TSF_TU]; // RQ10
      if (!st.quiet_en) begin
         next_st.quiet_left = 16'h0; // RQ13
      end else if (quiet_match) begin // RQ10
         next_st.next_quiet = st.next_quiet + st.quiet_period; // RQ11
         next_st.quiet_left = st.quiet_dur; // RQ12
      end else if (tu_tick && st.quiet_left != 16'h0) begin
         next_st.quiet_left = st.quiet_left - 16'h1; // RQ12
      end

      // Profiling counters
      halve = st.cyc_cnt == 32'hffffffff; // RQ8
      inc_tx = tx_frame | st.ctl_strobe; // RQ1 RQ6
      inc_rx = rx_frame | st.ctl_strobe; // RQ2 RQ6
      inc_clr = rx_clear | st.ctl_strobe; // RQ2 RQ6
      // Zero is a level: counters stay at zero while it is set
      if (st.ctl_zero) begin
         next_st.tx_cnt = 32'h0; // RQ5
         next_st.rx_cnt = 32'h0;
         next_st.clr_cnt = 32'h0;
         next_st.cyc_cnt = 32'h0;
      end else if (!st.ctl_freeze) begin // RQ7
         next_st.tx_cnt = cnt_next(st.tx_cnt, inc_tx, halve); // RQ1 RQ6
         next_st.rx_cnt = cnt_next(st.rx_cnt, inc_rx, halve); // RQ2
         next_st.clr_cnt = cnt_next(st.clr_cnt, inc_clr, halve); // RQ2
         next_st.cyc_cnt = cnt_next(st.cyc_cnt, 1'b1, halve); // RQ3
      end


      // Register writes; a counter write wins over its hardware update, but is ignored while the zero bit is set
      if (reg_wr) begin
         case (reg_addr)
            `MBPQ_OFS_TX_CNT: begin
               if (!st.ctl_zero) begin
                  next_st.tx_cnt = reg_wdata; // RQ9
               end
            end
            `MBPQ_OFS_RX_CNT: begin
               if (!st.ctl_zero) begin
                  next_st.rx_cnt = reg_wdata; // RQ9
               end
            end
            `MBPQ_OFS_CLR_CNT: begin
               if (!st.ctl_zero) begin
                  next_st.clr_cnt = reg_wdata; // RQ9
               end
            end
            `MBPQ_OFS_CYC_CNT: begin
               if (!st.ctl_zero) begin
                  next_st.cyc_cnt = reg_wdata; // RQ9
               end
            end
            `MBPQ_OFS_CNT_CTL: begin
               next_st.ctl_freeze = reg_wdata[`MBPQ_CTL_FREEZE];
               next_st.ctl_zero = reg_wdata[`MBPQ_CTL_ZERO];
               next_st.ctl_strobe = reg_wdata[`MBPQ_CTL_STROBE];
            end
            `MBPQ_OFS_QT1: begin
               next_st.next_quiet = reg_wdata[`MBPQ_QT1_NEXT];
               next_st.quiet_en = reg_wdata[`MBPQ_QT1_EN];
               next_st.quiet_ack_cts = reg_wdata[`MBPQ_QT1_ACKCTS];
            end
            `MBPQ_OFS_QT2: begin
               next_st.quiet_period = reg_wdata[`MBPQ_QT2_PERIOD]; // RQ14
               next_st.quiet_dur = reg_wdata[`MBPQ_QT2_DUR]; // RQ14
            end
            `MBPQ_OFS_TSF_STEP: begin
               next_st.tsf_step = reg_wdata[`MBPQ_STEP_F];
            end
            `MBPQ_OFS_NO_ACK_LOCATOR: begin
               bitpos = reg_wdata[`MBPQ_NO_ACK_LOCATOR_BIT];
               next_st.no_ack_locator_mask = reg_wdata[`MBPQ_NO_ACK_LOCATOR_MASK];
               // RQ17
               next_st.no_ack_locator_bit = (bitpos > `MBPQ_NO_ACK_LOCATOR_BIT_MAX) ? `MBPQ_NO_ACK_LOCATOR_BIT_MAX : bitpos;
               next_st.no_ack_locator_byte = reg_wdata[`MBPQ_NO_ACK_LOCATOR_BYTE];
            end
            `MBPQ_OFS_ERR_MASK: begin
               next_st.err_mask = reg_wdata;
            end
            `MBPQ_OFS_SIFS_ADJ: begin
               next_st.sifs_adj = reg_wdata[`MBPQ_SIFS_F];
            end
            `MBPQ_OFS_MIC_CTL: begin
               next_st.mic_ctl = reg_wdata[`MBPQ_MIC_CTL_F];
               next_st.mic_en = reg_wdata[`MBPQ_MIC_EN];
            end
            `MBPQ_OFS_MIC_SEL: begin
               next_st.mic_sel = reg_wdata[`MBPQ_MIC_SEL_F];
            end
            default: begin
            end
         endcase
      end


      // Register reads, data valid in the following cycle only
      if (reg_rd) begin
         case (reg_addr)
            `MBPQ_OFS_TX_CNT: begin
               next_st.rdata = st.tx_cnt;
            end
            `MBPQ_OFS_RX_CNT: begin
               next_st.rdata = st.rx_cnt;
            end
            `MBPQ_OFS_CLR_CNT: begin
               next_st.rdata = st.clr_cnt;
            end
            `MBPQ_OFS_CYC_CNT: begin
               next_st.rdata = st.cyc_cnt;
            end
            `MBPQ_OFS_CNT_CTL: begin
               next_st.rdata[`MBPQ_CTL_FREEZE] = st.ctl_freeze;
               next_st.rdata[`MBPQ_CTL_ZERO] = st.ctl_zero;
               next_st.rdata[`MBPQ_CTL_STROBE] = st.ctl_strobe;
            end
            `MBPQ_OFS_QT1: begin
               next_st.rdata[`MBPQ_QT1_NEXT] = st.next_quiet;
               next_st.rdata[`MBPQ_QT1_EN] = st.quiet_en;
               next_st.rdata[`MBPQ_QT1_ACKCTS] = st.quiet_ack_cts;
            end
            `MBPQ_OFS_QT2: begin
               next_st.rdata[`MBPQ_QT2_PERIOD] = st.quiet_period;
               next_st.rdata[`MBPQ_QT2_DUR] = st.quiet_dur;
            end
            `MBPQ_OFS_TSF_STEP: begin
               next_st.rdata[`MBPQ_STEP_F] = st.tsf_step;
            end
            `MBPQ_OFS_NO_ACK_LOCATOR: begin
               next_st.rdata[`MBPQ_NO_ACK_LOCATOR_MASK] = st.no_ack_locator_mask;
               next_st.rdata[`MBPQ_NO_ACK_LOCATOR_BIT] = st.no_ack_locator_bit;
               next_st.rdata[`MBPQ_NO_ACK_LOCATOR_BYTE] = st.no_ack_locator_byte;
            end
            `MBPQ_OFS_ERR_MASK: begin
               next_st.rdata = st.err_mask;
            end
            `MBPQ_OFS_SIFS_ADJ: begin
               next_st.rdata[`MBPQ_SIFS_F] = st.sifs_adj;
            end
            `MBPQ_OFS_MIC_CTL: begin
               next_st.rdata[`MBPQ_MIC_CTL_F] = st.mic_ctl;
               next_st.rdata[`MBPQ_MIC_EN] = st.mic_en;
            end
            `MBPQ_OFS_MIC_SEL: begin
               next_st.rdata[`MBPQ_MIC_SEL_F] = st.mic_sel;
            end
            default: begin
               next_st.rdata = 32'h0;
            end
         endcase
      end

      // Derived outputs
      next_st.tx_quiet = next_st.quiet_left != 16'h0; // RQ12
      next_st.no_ack_hit = st.no_ack_locator_mask[qos_ack_policy]; // RQ16
      // Only the low error numbers have a mask bit; all others are dropped
      next_st.err_drop = 1'b0;
      next_st.err_keep = 1'b0;
      if (bb_error_valid) begin
         if (bb_error_num > `MBPQ_ERR_MASKED_MAX) begin
            next_st.err_drop = 1'b1; // RQ19
         end else if (!st.err_mask[bb_error_num[4:0]]) begin
            next_st.err_drop = 1'b1; // RQ18
         end else begin
            next_st.err_keep = 1'b1; // RQ18
         end
      end
      // Adjustment is signed; the result wraps at ten bits
      adj_wide = {{2{st.sifs_adj[7]}}, st.sifs_adj};
      next_st.ack_sifs = sifs_table_us - adj_wide; // RQ20
      // RQ22
      next_st.mic_bits = st.mic_en ? mic_bit : 8'h0;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st.tx_cnt <= 32'h0;
         st.rx_cnt <= 32'h0;
         st.clr_cnt <= 32'h0;
         st.cyc_cnt <= 32'h0;
         st.ctl_freeze <= 1'b0;
         st.ctl_zero <= 1'b0;
         st.ctl_strobe <= 1'b0;
         st.sync_timer_step <= 32'h0;
         st.quiet_left <= 16'h0;
         st.tx_quiet <= 1'b0;
         st.err_mask <= 32'h0;
         st.sifs_adj <= 8'h0;
         st.mic_ctl <= 16'h0;
         st.mic_en <= 1'b0;
         st.mic_sel <= 16'h0;
         st.rdata <= 32'h0;
         st.no_ack_hit <= 1'b0;
         st.err_drop <= 1'b0;
         st.err_keep <= 1'b0;
         st.ack_sifs <= 10'h0;
         st.mic_bits <= 8'h0;
         st.next_quiet <= 16'(`MBPQ_RST_QT1);
         st.quiet_en <= 1'(`MBPQ_RST_QT1 >> `MBPQ_QT1_EN);
         st.quiet_ack_cts <= 1'(`MBPQ_RST_QT1 >> `MBPQ_QT1_ACKCTS);
         st.quiet_period <= 16'(`MBPQ_RST_QT2);
         st.quiet_dur <= 16'(`MBPQ_RST_QT2 >> 16);
         st.tsf_step <= `MBPQ_RST_TSF_STEP;
         st.prescale <= PRESCALE_TOP;
         st.no_ack_locator_mask <= 4'(`MBPQ_RST_NO_ACK_LOCATOR);
         st.no_ack_locator_bit <= 3'(`MBPQ_RST_NO_ACK_LOCATOR >> 4);
         st.no_ack_locator_byte <= 2'(`MBPQ_RST_NO_ACK_LOCATOR >> 7);
      end else if (clock_en) begin
         st <= next_st; // RQ4
      end
   end

   assign reg_rdata = st.rdata;
   assign tx_quiet = st.tx_quiet;
   assign quiet_ack_cts_enable = st.quiet_ack_cts;
   assign sync_timer = st.sync_timer_step;
   assign no_ack_hit = st.no_ack_hit;
   assign no_ack_bit_position = st.no_ack_locator_bit; // RQ17
   assign no_ack_byte_position = st.no_ack_locator_byte; // RQ17
   assign error_drop = st.err_drop;
   assign error_keep = st.err_keep;
   assign ack_sifs_us = st.ack_sifs;
   assign michael_tid_bits = st.mic_bits;
   assign michael_hw_enable = st.mic_en; // RQ22

endmodule

// file: bench/mbpq_regs_assertions.sv
// Port-level checks of the profiling and quiet-time register block.
// Assumes it is bound into mbpq_regs and sees only that module's ports.
`timescale 1ns/1ps
module mbpq_regs_chk #(
   parameter int USEC_CYCLES = 250
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clock_en,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic bb_error_valid,
   input wire logic [7:0] bb_error_num,
   input wire logic error_drop,
   input wire logic error_keep,
   input wire logic [2:0] no_ack_bit_position,
   input wire logic [31:0] sync_timer,
   input wire logic tx_quiet,
   input wire logic [7:0] michael_tid_bits,
   input wire logic michael_hw_enable
);
   logic [15:0] tu;
   assign tu = sync_timer[25:10];
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   AST_RDATA_IDLE: assert property (!reg_rd && clock_en |=> reg_rdata == 32'h0)
      else $error("read data not idle");
   AST_SLEEP_HOLD: assert property (!clock_en |=> $stable(sync_timer) && $stable(tx_quiet))
      else $error("state moved during sleep");
   AST_ERR_HIGH: assert property (bb_error_valid && clock_en && bb_error_num > 8'h1f |=>
      error_drop && !error_keep) else $error("high error number kept");
   AST_ERR_ONE: assert property (bb_error_valid && clock_en |=> error_drop ^ error_keep)
      else $error("error verdict not single");
   AST_ERR_IDLE: assert property (!bb_error_valid && clock_en |=> !error_drop && !error_keep)
      else $error("error verdict without error");
   AST_NO_ACK_LOCATOR_POS: assert property (no_ack_bit_position <= 3'h6)
      else $error("bit position above six");
   AST_TSF_STEP: assert property ($changed(sync_timer) |-> sync_timer - $past(sync_timer) <= 32'hff)
      else $error("sync timer jumped");
   AST_TSF_GAP: assert property ($changed(sync_timer) |=> (!$changed(sync_timer)) [*3])
      else $error("sync timer stepped too often");
   AST_MIC_OFF: assert property (!michael_hw_enable && !$past(michael_hw_enable) |->
      michael_tid_bits == 8'h0) else $error("integrity bits while disabled");
   AST_QUIET_HOLD: assert property ($fell(tx_quiet) && !$past(reg_wr) && !$past(reg_wr, 2) |->
      tu != $past(tu) || $past(tu) != $past(tu, 2)) else $error("quiet ended inside a unit");
endmodule

bind mbpq_regs mbpq_regs_chk #(.USEC_CYCLES(USEC_CYCLES)) mbpq_regs_chk_i (
   .clock(clock), .rst_b(rst_b), .clock_en(clock_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .bb_error_valid(bb_error_valid), .bb_error_num(bb_error_num),
   .error_drop(error_drop), .error_keep(error_keep), .no_ack_bit_position(no_ack_bit_position),
   .sync_timer(sync_timer), .tx_quiet(tx_quiet), .michael_tid_bits(michael_tid_bits),
   .michael_hw_enable(michael_hw_enable)
);

// file: bench/mbpq_bb_model.sv
// Baseband stand-in raising the three activity levels for set cycle counts.
// Assumes start is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
module mbpq_bb_model (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [7:0] n_tx,
   input wire logic [7:0] n_rx,
   input wire logic [7:0] n_clr,
   output logic tx_frame,
   output logic rx_frame,
   output logic rx_clear
);
   logic [7:0] left [3];
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         left <= '{8'h0, 8'h0, 8'h0};
      end else if (start) begin
         left <= '{n_tx, n_rx, n_clr};
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (left[i] != 8'h0) begin
               left[i] <= left[i] - 8'h1;
            end
         end
      end
   end
   assign tx_frame = left[0] != 8'h0;
   assign rx_frame = left[1] != 8'h0;
   assign rx_clear = left[2] != 8'h0;
endmodule

// file: bench/tb.sv
// Self-checking bench of the profiling and quiet-time register block.
// Assumes the design, its bound checker and the baseband stand-in are compiled first.
`timescale 1ns/1ps
`include "mbpq_defines.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s exp %h got %h", nm, (e), (g)); end end
module tb;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic clock_en = 1'b1;
   logic [15:0] reg_addr = 16'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [1:0] qos_ack_policy = 2'h0;
   logic bb_error_valid = 1'b0;
   logic [7:0] bb_error_num = 8'h0;
   logic [9:0] sifs_table_us = 10'h064;
   logic [3:0] qos_tid = 4'h0;
   logic start = 1'b0;
   logic [31:0] reg_rdata, sync_timer, t0;
   logic tx_frame, rx_frame, rx_clear, tx_quiet, quiet_ack_cts_enable, no_ack_hit, k;
   logic error_drop, error_keep, michael_hw_enable;
   logic [2:0] no_ack_bit_position;
   logic [1:0] no_ack_byte_position;
   logic [9:0] ack_sifs_us;
   logic [7:0] michael_tid_bits;
   logic [15:0] nq;
   logic [31:0] err_mask_val = 32'h80000021;
   logic [15:0] ra [9] = '{`MBPQ_OFS_QT1, `MBPQ_OFS_QT2, `MBPQ_OFS_TSF_STEP, `MBPQ_OFS_NO_ACK_LOCATOR,
      `MBPQ_OFS_ERR_MASK, `MBPQ_OFS_SIFS_ADJ, `MBPQ_OFS_MIC_CTL, `MBPQ_OFS_MIC_SEL, 16'h8110};
   logic [31:0] rv [9] = '{32'h20000, 32'h20001, 32'h1, 32'hcc, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   logic [7:0] en [6] = '{8'h00, 8'h01, 8'h05, 8'h1f, 8'h20, 8'hff};
   int mismatches = 0;
   int checks = 0;

   always #2 clock = ~clock;

   mbpq_regs #(.USEC_CYCLES(4)) mbpq_regs_i (
      .clock(clock), .rst_b(rst_b), .clock_en(clock_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_frame(tx_frame), .rx_frame(rx_frame), .rx_clear(rx_clear),
      .qos_ack_policy(qos_ack_policy), .bb_error_valid(bb_error_valid),
      .bb_error_num(bb_error_num), .sifs_table_us(sifs_table_us), .qos_tid(qos_tid),
      .tx_quiet(tx_quiet), .quiet_ack_cts_enable(quiet_ack_cts_enable), .sync_timer(sync_timer),
      .no_ack_hit(no_ack_hit), .no_ack_bit_position(no_ack_bit_position),
      .no_ack_byte_position(no_ack_byte_position), .error_drop(error_drop),
      .error_keep(error_keep), .ack_sifs_us(ack_sifs_us), .michael_tid_bits(michael_tid_bits),
      .michael_hw_enable(michael_hw_enable)
   );
   mbpq_bb_model mbpq_bb_model_i (
      .clock(clock), .rst_b(rst_b), .start(start), .n_tx(8'h05), .n_rx(8'h07), .n_clr(8'h09),
      .tx_frame(tx_frame), .rx_frame(rx_frame), .rx_clear(rx_clear)
   );

   task automatic complete_run();
      if (mismatches == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      `CHK("read data", e, reg_rdata)
   endtask
   task automatic counts(input logic [31:0] t, input logic [31:0] r, input logic [31:0] c,
      input logic [31:0] y);
      rd(`MBPQ_OFS_TX_CNT, t);
      rd(`MBPQ_OFS_RX_CNT, r);
      rd(`MBPQ_OFS_CLR_CNT, c);
      rd(`MBPQ_OFS_CYC_CNT, y);
   endtask
   // Zero, count 22 cycles in the given mode, then freeze; sleep drops 10 of them
   task automatic run(input logic [31:0] mode, input logic sleep);
      wr(`MBPQ_OFS_CNT_CTL, 32'h2);
      wr(`MBPQ_OFS_CNT_CTL, mode);
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      clock_en <= !sleep;
      repeat (10) @(posedge clock);
      clock_en <= 1'b1;
      repeat (9) @(posedge clock);
      wr(`MBPQ_OFS_CNT_CTL, 32'h1);
   endtask
   task automatic wq(input logic v);
      for (int i = 0; i < 300 && tx_quiet !== v; i++) tick(1);
      if (tx_quiet !== v) begin
         mismatches++;
         complete_run();
      end
   endtask

   initial begin
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      for (int i = 0; i < 9; i++) rd(ra[i], rv[i]);
      run(32'h0, 1'b0);
      counts(32'h5, 32'h7, 32'h9, 32'h16);
      run(32'h4, 1'b1);
      counts(32'hc, 32'hc, 32'hc, 32'hc);
      wr(`MBPQ_OFS_TX_CNT, 32'h10);
      wr(`MBPQ_OFS_RX_CNT, 32'h11);
      wr(`MBPQ_OFS_CLR_CNT, 32'h20);
      wr(`MBPQ_OFS_CYC_CNT, 32'hffffffff);
      wr(`MBPQ_OFS_CNT_CTL, 32'h0);
      wr(`MBPQ_OFS_CNT_CTL, 32'h1);
      counts(32'h8, 32'h8, 32'h10, 32'h80000001);
      wr(`MBPQ_OFS_CNT_CTL, 32'h2);
      counts(32'h0, 32'h0, 32'h0, 32'h0);
      for (int p = 0; p < 4; p++) begin
         @(posedge clock);
         qos_ack_policy <= 2'(p);
         tick(2);
         `CHK("no ack", (p >= 2), no_ack_hit)
      end
      wr(`MBPQ_OFS_NO_ACK_LOCATOR, 32'hffffffff);
      rd(`MBPQ_OFS_NO_ACK_LOCATOR, 32'h1ef);
      `CHK("bit pos", 3'h6, no_ack_bit_position)
      `CHK("byte pos", 2'h3, no_ack_byte_position)
      wr(`MBPQ_OFS_ERR_MASK, err_mask_val);
      for (int i = 0; i < 6; i++) begin
         @(posedge clock);
         bb_error_valid <= 1'b1;
         bb_error_num <= en[i];
         @(posedge clock);
         bb_error_valid <= 1'b0;
         #1;
         k = (en[i] < 8'h20) && err_mask_val[en[i][4:0]];
         `CHK("keep", k, error_keep)
         `CHK("drop", !k, error_drop)
      end
      wr(`MBPQ_OFS_SIFS_ADJ, 32'hfe);
      tick(2);
      `CHK("sifs", 10'h066, ack_sifs_us)
      wr(`MBPQ_OFS_SIFS_ADJ, 32'h5);
      tick(2);
      `CHK("sifs", 10'h05f, ack_sifs_us)
      wr(`MBPQ_OFS_MIC_SEL, 32'he4e4);
      wr(`MBPQ_OFS_MIC_CTL, 32'h1e4e4);
      @(posedge clock);
      qos_tid <= 4'h5;
      tick(2);
      `CHK("mic", 8'hee, michael_tid_bits)
      `CHK("mic en", 1'b1, michael_hw_enable)
      @(posedge clock);
      qos_tid <= 4'ha;
      tick(2);
      `CHK("mic", 8'h22, michael_tid_bits)
      wr(`MBPQ_OFS_MIC_CTL, 32'he4e4);
      tick(2);
      `CHK("mic", 8'h00, michael_tid_bits)
      `CHK("mic en", 1'b0, michael_hw_enable)
      wr(`MBPQ_OFS_TSF_STEP, 32'hff);
      tick(1);
      t0 = sync_timer;
      tick(4);
      `CHK("timer step", 32'hff, sync_timer - t0)
      nq = sync_timer[25:10] + 16'h2;
      wr(`MBPQ_OFS_QT2, 32'h00010003);
      wr(`MBPQ_OFS_QT1, {15'h0, 1'b1, nq});
      wq(1'b1);
      `CHK("quiet start", nq, sync_timer[25:10])
      rd(`MBPQ_OFS_QT1, {15'h0, 1'b1, nq + 16'h3});
      wq(1'b0);
      `CHK("quiet end", nq + 16'h1, sync_timer[25:10])
      wq(1'b1);
      `CHK("quiet next", nq + 16'h3, sync_timer[25:10])
      wr(`MBPQ_OFS_QT1, {14'h0, 1'b1, 1'b0, nq + 16'h4});
      tick(2);
      for (int i = 0; i < 80; i++) begin
         tick(1);
         `CHK("quiet off", 1'b0, tx_quiet)
      end
      `CHK("ack cts", 1'b1, quiet_ack_cts_enable)
      complete_run();
   end
endmodule
